// ---- pkg/iprio_arb_if.sv ----
/*
 * Carrier between the register block and the level arbiter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface iprio_arb_if;
   iprio_pkg::iprio_vec_t   req;
   iprio_pkg::iprio_vec_t   upper;
   iprio_pkg::iprio_vec_t   lower;
   logic                    win_valid;
   iprio_pkg::iprio_src_t   win_src;
   iprio_pkg::iprio_level_t win_level;

   modport arb (
      input  req,
      input  upper,
      input  lower,
      output win_valid,
      output win_src,
      output win_level
   );
   modport ctl (
      output req,
      output upper,
      output lower,
      input  win_valid,
      input  win_src,
      input  win_level
   );
endinterface
`default_nettype wire

// ---- pkg/iprio_map.svh ----
/*
 * Register map, field positions and reset values of the interrupt
 * priority register block.
 * Assumes a 32-bit APB bus with one aligned word per register.
 */
`ifndef IPRIO_MAP_SVH
`define IPRIO_MAP_SVH

// ==========================================================
// register indices, byte address is four times the index
// ==========================================================
`define IPRIO_IDX_UPPER      8'hB7
`define IPRIO_IDX_LOWER      8'hB8
`define IPRIO_IDX_ENABLE     8'hA8
`define IPRIO_IDX_STATUS     8'hB9
`define IPRIO_ADDR_UPPER     12'h2DC
`define IPRIO_ADDR_LOWER     12'h2E0
`define IPRIO_ADDR_ENABLE    12'h2A0
`define IPRIO_ADDR_STATUS    12'h2E4

// ==========================================================
// fields and reset values
// ==========================================================
`define IPRIO_NUM_SRC        7
`define IPRIO_SRC_MSB        6
`define IPRIO_GEN_BIT        7
`define IPRIO_PRIO_RST       7'h00
`define IPRIO_EN_RST         7'h00
`define IPRIO_GEN_RST        1'h0
`define IPRIO_ST_SRC_LSB     0
`define IPRIO_ST_LVL_LSB     3
`define IPRIO_ST_VALID_BIT   5
`define IPRIO_ST_ISVC_LSB    8
`define IPRIO_SRC_TRAP       3'h7
`define IPRIO_LVL_MAX        2'h3

`endif

// ---- pkg/iprio_pkg.sv ----
/*
 * Types shared by the interrupt priority block.
 * Assumes iprio_map.svh for field widths.
 */
package iprio_pkg;
   typedef logic [1:0] iprio_level_t;
   typedef logic [2:0] iprio_src_t;
   typedef logic [6:0] iprio_vec_t;

   typedef struct packed {
      iprio_vec_t   upper;
      iprio_vec_t   lower;
      iprio_vec_t   enable;
      logic         global_en;
      logic [3:0]   in_service;
      logic [31:0]  prdata;
      logic         valid;
      iprio_src_t   src;
      iprio_level_t level;
   } iprio_state_s;
endpackage

// ---- tb/interrupt_priority_regs_bench.sv ----
/* Self-checking bench of the interrupt priority registers.
   Assumes iprio_regs with zero-wait APB and the sequencer model. */
`timescale 1ns/1ps
`default_nettype none
`include "iprio_map.svh"
module interrupt_priority_regs_bench;
   logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic [6:0]  src_req;
   logic        trap_req, irq_ack, irq_ret, irq_valid, go;
   logic [2:0]  irq_src;
   logic [1:0]  irq_level;
   logic [7:0]  hold;
   int          err_count, n_compared, up, lo, en, rq, n;

   iprio_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_req(src_req), .trap_req(trap_req), .irq_ack(irq_ack),
      .irq_ret(irq_ret), .irq_valid(irq_valid), .irq_src(irq_src),
      .irq_level(irq_level));
   iprio_seq_model u_seq (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go),
      .hold(hold), .irq_valid(irq_valid), .irq_ack(irq_ack),
      .irq_ret(irq_ret));

   always #20 ref_clk = ~ref_clk;

   // ==========================================================
   // helpers
   // ==========================================================
   task automatic complete_run;
      if (err_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // idle edge at the end so a following setup never lands in the
   // same time step as the release
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) err_count++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x,
                     input logic er);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk("prdata", q, x);
      chk("pslverr", {31'h0, e}, {31'h0, er});
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // winner as index*4+level, -1 when nothing is presented
   function automatic int win(int req, int u, int l, int e);
      int b;
      int bl;
      int v;
      b = -1;
      bl = 0;
      for (int i = 0; i < 7; i++) begin
         v = 2 * u[i] + l[i];
         if (e[7] && e[i] && req[i] && (b < 0 || v > bl)) begin
            b = i;
            bl = v;
         end
      end
      return (b < 0) ? -1 : b * 4 + bl;
   endfunction

   task automatic irq_chk(input int w);
      chk("irq_valid", {31'h0, irq_valid}, 32'(w >= 0));
      if (w >= 0) begin
         chk("irq_src", {29'h0, irq_src}, 32'(w / 4));
         chk("irq_level", {30'h0, irq_level}, 32'(w % 4));
      end
   endtask

   // ==========================================================
   // scenarios
   // ==========================================================
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      complete_run;
   end

   initial begin
      {ref_clk, psel, penable, pwrite, trap_req, go} = 6'h00;
      sys_rst = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      src_req = 7'h00;
      hold = 8'h3C;
      rnd = 32'h47A8;
      err_count = 0;
      n_compared = 0;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(`IPRIO_ADDR_UPPER, 32'h0, 1'b0);
      rd(`IPRIO_ADDR_LOWER, 32'h0, 1'b0);
      rd(12'h000, 32'h0, 1'b1);
      for (int i = 0; i < 16; i++) begin
         repeat (8) rnd = lfsr(rnd);
         up = rnd[6:0];
         lo = rnd[14:8];
         en = rnd[22:16] | ((i % 4 != 3) ? 128 : 0);
         rq = rnd[30:24];
         wr(`IPRIO_ADDR_UPPER, up);
         wr(`IPRIO_ADDR_LOWER, lo);
         wr(`IPRIO_ADDR_ENABLE, en);
         rd(`IPRIO_ADDR_UPPER, up, 1'b0);
         rd(`IPRIO_ADDR_LOWER, lo, 1'b0);
         src_req <= rnd[30:24];
         repeat (2) @(posedge ref_clk);
         irq_chk(win(rq, up, lo, en));
      end
      wr(`IPRIO_ADDR_ENABLE, 32'h0);
      trap_req <= 1'b1;
      repeat (2) @(posedge ref_clk);
      irq_chk(31);
      trap_req <= 1'b0;
      src_req <= 7'h00;
      wr(`IPRIO_ADDR_UPPER, 32'h41);
      wr(`IPRIO_ADDR_LOWER, 32'h42);
      wr(`IPRIO_ADDR_ENABLE, 32'hFF);
      go <= 1'b1;
      src_req <= 7'h01;
      n = 0;
      while (irq_ack !== 1'b1 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      chk("irq_ack", {31'h0, irq_ack}, 32'h1);
      repeat (3) @(posedge ref_clk);
      irq_chk(-1);
      src_req <= 7'h03;
      repeat (2) @(posedge ref_clk);
      irq_chk(-1);
      go <= 1'b0;
      src_req <= 7'h43;
      repeat (2) @(posedge ref_clk);
      irq_chk(27);
      rd(`IPRIO_ADDR_STATUS, 32'h43E, 1'b0);
      // the return frees level 2; the level 3 request stays shown
      n = 0;
      while (irq_ret !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      chk("irq_ret", {31'h0, irq_ret}, 32'h1);
      @(posedge ref_clk);
      rd(`IPRIO_ADDR_STATUS, 32'h3E, 1'b0);
      complete_run;
   end
endmodule
`default_nettype wire

// ---- tb/iprio_seq_model.sv ----
/* Sequencer model: takes a presented request into service and ends
   it a set number of cycles later.
   Assumes the clock and reset of the register block. */
`timescale 1ns/1ps
`default_nettype none
module iprio_seq_model (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       go,
   input  wire logic [7:0] hold,
   input  wire logic       irq_valid,
   output logic            irq_ack,
   output logic            irq_ret
);
   logic [7:0] cnt;
   logic       take;
   assign take = go && irq_valid && cnt == 8'h00;
   // one service at a time; the count runs on after go drops
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 8'h00;
         irq_ack <= 1'b0;
         irq_ret <= 1'b0;
      end else begin
         irq_ack <= take;
         irq_ret <= cnt == 8'h01;
         if (take) cnt <= hold;
         else if (cnt != 8'h00) cnt <= cnt - 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/iprio_arbiter.sv ----
/*
 * Combinational level arbiter: picks the pending request with the
 * highest two-bit level.
 * Assumes requests arrive already masked by the enables.
 */
`timescale 1ns/1ps
`default_nettype none
`include "iprio_map.svh"
module iprio_arbiter (
   iprio_arb_if.arb arb
);
   iprio_pkg::iprio_level_t lvl [`IPRIO_NUM_SRC];

   // ==========================================================
   // per-source level from the bit pair
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < `IPRIO_NUM_SRC; g++) begin : g_lvl
         assign lvl[g] = {arb.upper[g], arb.lower[g]};
      end
   endgenerate

   // ==========================================================
   // selection; scanning downward with >= lets the lower index
   // win a tie, so external 0 beats all others at equal level
   // ==========================================================
   always_comb begin
      arb.win_valid = 1'b0;
      arb.win_src   = 3'h0;
      arb.win_level = 2'h0;
      for (int i = `IPRIO_SRC_MSB; i >= 0; i--) begin
         if (arb.req[i] && (!arb.win_valid || lvl[i] >= arb.win_level)) begin
            arb.win_valid = 1'b1;
            arb.win_src   = 3'(i);
            arb.win_level = lvl[i];
         end
      end
   end
endmodule
`default_nettype wire

// ---- verilog/iprio_regs.sv ----
/*
 * Interrupt priority registers with enable gating, level arbitration
 * and nesting by in-service level, reached over APB.
 * Assumes one clock, zero-wait APB master, and source requests held
 * until serviced; irq_ack and irq_ret are one-cycle pulses from the
 * sequencer.
 */
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "iprio_map.svh"
module iprio_regs #(
   parameter int ADDR_W = 12
) (
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [6:0]        src_req,
   input  wire logic              trap_req,
   input  wire logic              irq_ack,
   input  wire logic              irq_ret,
   output logic                   irq_valid,
   output logic [2:0]             irq_src,
   output logic [1:0]             irq_level
);
   initial begin
      if (ADDR_W < 12 || ADDR_W > 32)
         $error("iprio_regs: ADDR_W must lie between 12 and 32");
   end

   iprio_pkg::iprio_state_s st_reg;
   iprio_pkg::iprio_state_s st_next;
   iprio_arb_if             arb_bus ();

   // ==========================================================
   // decoding helpers
   // ==========================================================
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a == ADDR_W'(`IPRIO_ADDR_UPPER))  ||
                 (a == ADDR_W'(`IPRIO_ADDR_LOWER))  ||
                 (a == ADDR_W'(`IPRIO_ADDR_ENABLE)) ||
                 (a == ADDR_W'(`IPRIO_ADDR_STATUS));
   endfunction

   // {any in service, highest level in service}
   function automatic logic [2:0] top_service(input logic [3:0] s);
      top_service = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (s[i])
            top_service = {1'b1, 2'(i)};
      end
   endfunction

   // ==========================================================
   // arbiter
   // ==========================================================
   assign arb_bus.req   = src_req & st_reg.enable &
                          {`IPRIO_NUM_SRC{st_reg.global_en}};
   assign arb_bus.upper = st_reg.upper;
   assign arb_bus.lower = st_reg.lower;

   iprio_arbiter u_arb (
      .arb (arb_bus.arb)
   );

   // ==========================================================
   // next state
   // ==========================================================
   logic [2:0]  svc_top;
   logic        preempt_ok;
   logic        wr_en;
   logic [31:0] rd_val;
   logic [3:0]  isvc;

   assign svc_top    = top_service(st_reg.in_service);
   assign preempt_ok = !svc_top[2] ||
                       (arb_bus.win_level > svc_top[1:0]);
   assign wr_en      = psel && penable && pwrite;

   always_comb begin
      st_next = st_reg;
      isvc    = st_reg.in_service;
      rd_val  = 32'h0;
      // bit 7 stays zero on read of upper, lower and status, so the reserved bit is defined; enable returns global_en there
      case (paddr)
         ADDR_W'(`IPRIO_ADDR_UPPER):  rd_val[6:0] = st_reg.upper;
         ADDR_W'(`IPRIO_ADDR_LOWER):  rd_val[6:0] = st_reg.lower;
         ADDR_W'(`IPRIO_ADDR_ENABLE): begin
            rd_val[6:0]           = st_reg.enable;
            rd_val[`IPRIO_GEN_BIT] = st_reg.global_en;
         end
         ADDR_W'(`IPRIO_ADDR_STATUS): begin
            rd_val[`IPRIO_ST_SRC_LSB+:3]  = st_reg.src;
            rd_val[`IPRIO_ST_LVL_LSB+:2]  = st_reg.level;
            rd_val[`IPRIO_ST_VALID_BIT]   = st_reg.valid;
            rd_val[`IPRIO_ST_ISVC_LSB+:4] = st_reg.in_service;
         end
         default: rd_val = 32'h0;
      endcase
      // data captured in setup so the access phase needs no wait
      if (psel && !penable)
         st_next.prdata = rd_val;

      if (wr_en) begin
         // bit 7 of upper and lower ignored on write: software is expected to write zero; on enable it sets global_en
         case (paddr)
            ADDR_W'(`IPRIO_ADDR_UPPER):
               st_next.upper = pwdata[6:0];
            ADDR_W'(`IPRIO_ADDR_LOWER):
               st_next.lower = pwdata[6:0];
            ADDR_W'(`IPRIO_ADDR_ENABLE): begin
               st_next.enable    = pwdata[6:0];
               st_next.global_en = pwdata[`IPRIO_GEN_BIT];
            end
            default: st_next.upper = st_reg.upper;
         endcase
      end

      // return first, then acknowledge, so a new entry is never lost
      if (irq_ret && svc_top[2])
         isvc[svc_top[1:0]] = 1'b0;
      if (irq_ack && st_reg.valid && st_reg.src != `IPRIO_SRC_TRAP)
         isvc[st_reg.level] = 1'b1;
      st_next.in_service = isvc;

      // trap ignores enables and nesting
      if (trap_req) begin
         st_next.valid = 1'b1;
         st_next.src   = `IPRIO_SRC_TRAP;
         st_next.level = `IPRIO_LVL_MAX;
      end else begin
         st_next.valid = arb_bus.win_valid && preempt_ok;
         st_next.src   = arb_bus.win_src;
         st_next.level = arb_bus.win_level;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg            <= '0;
         st_reg.upper      <= `IPRIO_PRIO_RST;
         st_reg.lower      <= `IPRIO_PRIO_RST;
         st_reg.enable     <= `IPRIO_EN_RST;
         st_reg.global_en  <= `IPRIO_GEN_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign prdata    = st_reg.prdata;
   assign pready    = psel && penable;
   assign pslverr   = psel && penable && !addr_hit(paddr);
   assign irq_valid = st_reg.valid;
   assign irq_src   = st_reg.src;
   assign irq_level = st_reg.level;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // level held against last cycle's bit pair of the shown source
   prio_decode_a: assert property (
      irq_valid && irq_src != `IPRIO_SRC_TRAP && !$past(sys_rst)
      |-> irq_level == {1'($past(st_reg.upper) >> irq_src),
                        1'($past(st_reg.lower) >> irq_src)})
      else $error("level does not match bit pair");
   upper_write_a: assert property (
      wr_en && paddr == ADDR_W'(`IPRIO_ADDR_UPPER)
      |=> st_reg.upper == $past(pwdata[6:0]) ##1 $stable(st_reg.upper)
          || $past(wr_en))
      else $error("upper priority write lost");
   lower_write_a: assert property (
      wr_en && paddr == ADDR_W'(`IPRIO_ADDR_LOWER)
      |=> st_reg.lower == $past(pwdata[6:0]))
      else $error("lower priority write lost");
   rsvd_read_a: assert property (
      psel && !penable && (paddr == ADDR_W'(`IPRIO_ADDR_UPPER) ||
      paddr == ADDR_W'(`IPRIO_ADDR_LOWER)) |=> prdata[31:7] == 25'h0)
      else $error("reserved bits read nonzero");
   global_mask_a: assert property (
      !st_reg.global_en && !trap_req |=> !irq_valid)
      else $error("request passed with global enable clear");
   enable_mask_a: assert property (
      !trap_req && !(|(src_req & st_reg.enable)) |=> !irq_valid)
      else $error("request passed from a disabled source");
   preempt_lvl_a: assert property (
      irq_valid && irq_src != `IPRIO_SRC_TRAP &&
      $past(svc_top[2]) |-> irq_level > $past(svc_top[1:0]))
      else $error("request did not outrank service level");
   nest_ack_a: assert property (
      irq_ack && irq_valid && !irq_ret &&
      irq_src != `IPRIO_SRC_TRAP |=> st_reg.in_service[$past(irq_level)])
      else $error("acknowledged level not in service");
   ret_clear_a: assert property (
      irq_ret && !irq_ack && svc_top[2] |=> !st_reg.in_service[$past(svc_top[1:0])])
      else $error("returned level still in service");

   ack_seen_c:   cover property (irq_valid && irq_ack);
   preempt_c:    cover property (irq_valid && svc_top[2] &&
                                 irq_src != `IPRIO_SRC_TRAP);
   trap_masked_c: cover property (!st_reg.global_en && trap_req
                                  ##1 irq_valid);
   ret_seen_c:   cover property (irq_ret && svc_top[2]);
endmodule
`default_nettype wire
